// File: bench/galvo_head_model.sv
// Behavioural model of one galvo head at the far end of the link.
`timescale 1ns/100ps
module galvo_head_model (
   input  wire logic  tx_clk_in,
   input  wire logic  tx_fs_in,
   input  wire logic  tx_x_in,
   input  wire logic  tx_y_in,
   input  wire logic  bad_echo_in,
   input  wire logic  mute_in,
   input  wire logic [4:0] bits_in,
   output logic       rx_clk_out,
   output logic       rx_fs_out,
   output logic       rx_status_out,
   output logic       rx_echo_out,
   output logic [15:0] got_x_out,
   output logic [15:0] got_y_out,
   output int         frames_out
);
   logic [15:0] sx, sy, st, ec;
   int          n;
   event        go;
   initial begin
      {rx_clk_out, rx_fs_out, rx_status_out, rx_echo_out} = 4'h0;
      {got_x_out, got_y_out, sx, sy} = '0;
      n = 0;
      frames_out = 0;
      // A few clock pulses at the start carry the reset across; later the clock runs only for each unmuted frame plus one pulse after it.
      repeat (4) begin
         #80 rx_clk_out = 1'b1;
         #80 rx_clk_out = 1'b0;
      end
   end
   always @(negedge tx_clk_in) begin
      if (tx_fs_in) begin
         sx = {sx[14:0], tx_x_in};
         sy = {sy[14:0], tx_y_in};
         n = n + 1;
         if (n == 16) begin
            n = 0;
            got_x_out = sx;
            got_y_out = sy;
            frames_out = frames_out + 1;
            if (!mute_in) ->go;
         end
      end else n = 0;
   end
   always @(go) begin
      st = ~sx;
      ec = (sx ^ sy) ^ {16{bad_echo_in}};
      for (int i = 0; i < bits_in; i++) begin
         #80 rx_clk_out = 1'b1;
         rx_fs_out = 1'b1;
         rx_status_out = st[15-i];
         rx_echo_out = ec[15-i];
         #80 rx_clk_out = 1'b0;
      end
      #80 rx_clk_out = 1'b1;
      rx_fs_out = 1'b0;
      rx_status_out = ~rx_status_out;
      rx_echo_out = ~rx_echo_out;
      #80 rx_clk_out = 1'b0;
   end
endmodule : galvo_head_model

// File: bench/galvo_link_chk.sv
// Concurrent checks on the ports of the galvo serial link.
`timescale 1ns/100ps
module galvo_link_chk #(
   parameter int HEADS    = 2,
   parameter int HALF_CYC = 5
) (
   input wire logic             sys_clk_in,
   input wire logic             rst_n_in,
   input wire logic [HEADS-1:0] tx_busy_out,
   input wire logic [HEADS-1:0] tx_bit_clock_out,
   input wire logic [HEADS-1:0] tx_frame_sync_out,
   input wire logic [HEADS-1:0] tx_x_coord_line_out,
   input wire logic [HEADS-1:0] tx_y_coord_line_out,
   input wire logic [HEADS-1:0] rx_valid_out,
   input wire logic [HEADS-1:0] rx_frame_error_out,
   input wire logic [HEADS-1:0] link_error_out
);
   ////////////////////////////////////////////////////////////////////////////////
   logic [11:0] hi_cnt_ff;
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in || !tx_frame_sync_out[0]) hi_cnt_ff <= 12'h000;
      else hi_cnt_ff <= hi_cnt_ff + 12'h001;
   end
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!rst_n_in);
   ////////////////////////////////////////////////////////////////////////////////
   a_sync_busy_same: assert property (tx_frame_sync_out == tx_busy_out)
      else $error("Frame sync differs from busy.");
   a_frame_len: assert property ($fell(tx_frame_sync_out[0]) |-> hi_cnt_ff == 12'(32 * HALF_CYC))
      else $error("Frame sync not high for sixteen bit periods.");
   a_frame_gap: assert property ($fell(tx_frame_sync_out[0]) |-> !tx_frame_sync_out[0] [*8])
      else $error("Frame sync low gap too short.");
   a_idle_lines_zero: assert property (!tx_frame_sync_out[1] |->
      !tx_x_coord_line_out[1] && !tx_y_coord_line_out[1])
      else $error("Data line active outside a frame.");
   a_data_on_rise: assert property ($changed(tx_x_coord_line_out[0]) || $changed(tx_y_coord_line_out[0])
      |-> $rose(tx_bit_clock_out[0]))
      else $error("Data changed away from a clock rise.");
   a_sync_on_rise: assert property ($changed(tx_frame_sync_out[0]) |-> $rose(tx_bit_clock_out[0]))
      else $error("Frame sync changed away from a clock rise.");
   a_valid_one_cycle: assert property (rx_valid_out[0] |=> !rx_valid_out[0])
      else $error("Receive valid longer than one cycle.");
   a_err_with_valid: assert property ((link_error_out & ~rx_valid_out) == '0)
      else $error("Link error without receive valid.");
   a_valid_err_excl: assert property ((rx_frame_error_out & rx_valid_out) == '0)
      else $error("Frame error together with valid.");
endmodule : galvo_link_chk

bind galvo_serial_link galvo_link_chk #(.HEADS(HEADS), .HALF_CYC(HALF_CYC)) chk (
   .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .tx_busy_out(tx_busy_out),
   .tx_bit_clock_out(tx_bit_clock_out), .tx_frame_sync_out(tx_frame_sync_out),
   .tx_x_coord_line_out(tx_x_coord_line_out), .tx_y_coord_line_out(tx_y_coord_line_out),
   .rx_valid_out(rx_valid_out), .rx_frame_error_out(rx_frame_error_out), .link_error_out(link_error_out));

// File: bench/tb.sv
// Self-checking testbench for the galvo serial link.
`timescale 1ns/100ps
module tb;
   logic                          sys_clk_in = 1'b0;
   logic                          rst_n_in = 1'b0;
   galvo_pkg::coord_pair_t [1:0]  coord_in = '0;
   logic [1:0]                    coord_valid_in = 2'h0, bad = 2'h0, mute = 2'h0;
   logic [4:0]                    bits [2] = '{5'h10, 5'h10};
   logic [1:0]                    ready, busy, tck, tfs, txx, txy, rck, rfs, rst, rec, rv, rfe, le;
   galvo_pkg::rx_word_t [1:0]     rw;
   logic [15:0]                   gx [2], gy [2];
   int                            frames [2];
   int                            mismatches = 0, samples_checked = 0;
   galvo_pkg::rx_word_t           w [2];
   logic                          wle [2], wfe [2];
   initial forever #2 sys_clk_in = ~sys_clk_in;
   galvo_serial_link dut (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .coord_in(coord_in),
      .coord_valid_in(coord_valid_in), .coord_ready_out(ready), .tx_busy_out(busy), .tx_bit_clock_out(tck),
      .tx_frame_sync_out(tfs), .tx_x_coord_line_out(txx), .tx_y_coord_line_out(txy), .rx_bit_clock_in(rck),
      .rx_frame_sync_in(rfs), .rx_status_line_in(rst), .rx_xor_echo_line_in(rec), .rx_word_out(rw),
      .rx_valid_out(rv), .rx_frame_error_out(rfe), .link_error_out(le));
   for (genvar h = 0; h < 2; h++) begin : g_head
      galvo_head_model head (.tx_clk_in(tck[h]), .tx_fs_in(tfs[h]), .tx_x_in(txx[h]), .tx_y_in(txy[h]),
         .bad_echo_in(bad[h]), .mute_in(mute[h]), .bits_in(bits[h]), .rx_clk_out(rck[h]), .rx_fs_out(rfs[h]),
         .rx_status_out(rst[h]), .rx_echo_out(rec[h]), .got_x_out(gx[h]), .got_y_out(gy[h]),
         .frames_out(frames[h]));
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic report_and_stop();
      $display("Comparisons %0d, mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : report_and_stop
   task automatic push_wait(input logic [63:0] p);
      logic [1:0] got;
      got = 2'h0;
      coord_in = p;
      coord_valid_in = 2'h3;
      @(posedge sys_clk_in);
      #1 coord_valid_in = 2'h0;
      for (int k = 0; k < 3000 && got != 2'h3; k++) begin
         @(posedge sys_clk_in);
         #1;
         for (int h = 0; h < 2; h++) begin
            if (rv[h] === 1'b1 || rfe[h] === 1'b1) begin
               got[h] = 1'b1;
               w[h] = rw[h];
               wle[h] = le[h];
               wfe[h] = rfe[h];
            end
         end
      end
      if (got != 2'h3) begin
         mismatches++;
         report_and_stop();
      end
   endtask : push_wait
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_pair();
      logic [63:0] p;
      p = 64'h1234FFFF_80007FFF;
      push_wait(p);
      for (int h = 0; h < 2; h++) begin
         check({gx[h], gy[h]}, p[32*h +: 32]);
         check(w[h].status, {~p[32*h+16 +: 16]});
         check(w[h].echo, p[32*h+16 +: 16] ^ p[32*h +: 16]);
         check({w[h].short_frame, wle[h], wfe[h]}, 3'h0);
      end
      $display("t_pair done");
   endtask : t_pair
   task automatic t_bad_echo();
      bad = 2'h2;
      push_wait(64'h00010002_7FFF8000);
      check({wle[1], wle[0]}, 2'h2);
      check({gx[0], gy[0]}, 32'h7FFF8000);
      bad = 2'h0;
      $display("t_bad_echo done");
   endtask : t_bad_echo
   task automatic t_short();
      bits[0] = 5'h05;
      push_wait(64'hA5A50F0F_C3C3_3C3C);
      check({wfe[1], wfe[0]}, 2'h1);
      check(w[1].echo, 16'hAAAA);
      bits[0] = 5'h10;
      $display("t_short done");
   endtask : t_short
   task automatic t_fifo();
      int acc, f0, f1, k;
      logic [15:0] last;
      acc = 0;
      f0 = frames[0];
      f1 = frames[1];
      mute = 2'h3;
      for (k = 0; k < 12; k++) begin
         coord_in[0] = {16'(k), ~16'(k)};
         coord_valid_in = 2'h1;
         if (ready[0] === 1'b1) begin
            acc++;
            last = 16'(k);
         end
         @(posedge sys_clk_in);
         #1;
      end
      coord_valid_in = 2'h0;
      check(acc < 12, 1'b1);
      for (k = 0; k < 5000 && (frames[0] != f0 + acc || busy[0] !== 1'b0); k++) @(posedge sys_clk_in);
      if (k >= 5000) begin
         mismatches++;
         report_and_stop();
      end
      check(frames[0] - f0, acc);
      check(gx[0], last);
      check(ready, 2'h3);
      check(frames[1] - f1, 0);
      mute = 2'h0;
      $display("t_fifo done");
   endtask : t_fifo
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (3) @(posedge sys_clk_in);
      #1 rst_n_in = 1'b1;
      t_pair();
      t_bad_echo();
      t_short();
      t_fifo();
      t_pair();
      report_and_stop();
   end
endmodule : tb

// File: verilog/coord_fifo.sv
// Small FIFO with registered read data, used for coordinate pairs.
`timescale 1ns/100ps
`include "galvo_consts.svh"

module coord_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = `TX_FIFO_DEPTH
) (
   input  wire logic             sys_clk_in,
   input  wire logic             rst_n_in,
   input  wire logic             in_valid_in,
   output logic                  in_ready_out,
   input  wire logic [WIDTH-1:0] in_data_in,
   output logic                  out_valid_out,
   input  wire logic             out_ready_in,
   output logic [WIDTH-1:0]      out_data_out
);

   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);

   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [PW-1:0]    wr_ptr_ff;
   logic [PW-1:0]    rd_ptr_ff;
   logic [CW-1:0]    count_ff;
   logic [CW-1:0]    nxt_count;
   logic             push;
   logic             pop;
   logic             not_full_ff;
   logic             not_empty_ff;
   logic [WIDTH-1:0] rd_data_ff;

   function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
      ptr_inc = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
   endfunction : ptr_inc

   assign push = in_valid_in && not_full_ff;
   assign pop  = out_ready_in && not_empty_ff;

   always_comb begin
      nxt_count = count_ff;
      if (push && !pop) begin
         nxt_count = CW'(count_ff + 1'b1);
      end else if (pop && !push) begin
         nxt_count = CW'(count_ff - 1'b1);
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (push) begin
         mem_ff[wr_ptr_ff] <= in_data_in;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         wr_ptr_ff    <= '0;
         rd_ptr_ff    <= '0;
         count_ff     <= '0;
         not_full_ff  <= 1'b1;
         not_empty_ff <= 1'b0;
         rd_data_ff   <= '0;
      end else begin
         if (push) begin
            wr_ptr_ff <= ptr_inc(wr_ptr_ff);
         end
         if (pop) begin
            rd_ptr_ff  <= ptr_inc(rd_ptr_ff);
            rd_data_ff <= mem_ff[rd_ptr_ff];
         end
         count_ff     <= nxt_count;
         not_full_ff  <= (nxt_count != CW'(DEPTH));
         not_empty_ff <= (nxt_count != '0);
      end
   end

   assign in_ready_out  = not_full_ff;
   assign out_valid_out = not_empty_ff;
   assign out_data_out  = rd_data_ff;

endmodule : coord_fifo

// File: verilog/galvo_consts.svh
// Constants for the dual galvo serial link: widths, timing and reset values.
`ifndef GALVO_CONSTS_SVH
`define GALVO_CONSTS_SVH

`define HEAD_COUNT          2
`define COORD_WIDTH         16
`define COORD_MSB           15
`define BIT_COUNT_LAST      4'hF
`define BIT_COUNT_RESET     4'h0
`define SYS_CLK_PERIOD_NS   4
`define TX_HALF_PERIOD_NS   20
`define TX_HALF_CYCLES      ((`TX_HALF_PERIOD_NS + `SYS_CLK_PERIOD_NS - 1) / `SYS_CLK_PERIOD_NS)
`define TX_FIFO_DEPTH       4
`define WORD_RESET          16'h0000

`endif

// File: verilog/galvo_pkg.sv
// Types shared by the galvo serial link and its testbench.
package galvo_pkg;

   typedef struct packed {
      logic signed [15:0] x;
      logic signed [15:0] y;
   } coord_pair_t;

   typedef struct packed {
      logic        short_frame;
      logic [15:0] status;
      logic [15:0] echo;
   } rx_word_t;

   typedef enum logic {
      TX_IDLE  = 1'b0,
      TX_SHIFT = 1'b1
   } tx_state_t;

endpackage : galvo_pkg

// File: verilog/galvo_serial_link.sv
// Dual synchronous serial port driving two digital galvo heads.
//
// Contract
// - Two independent port pairs; each sends and receives 16-bit words independently.
// - X word on X line, Y word on Y line, sharing clock and frame sync.
// - Frame sync rises at word start and stays high for the whole word.
// - Frame syncs are active high; low means no word in progress.
// - Data leaves MSB first, changing on the transmit clock rising edge.
// - Receiver samples both lines on the falling edge of the receive clock.
// - Frame sync and data are referenced to the transmit clock rising edge.
// - Coordinates are signed 16-bit values, range -32768 to +32767.
`timescale 1ns/100ps
`include "galvo_consts.svh"

module galvo_serial_link #(
   parameter int HEADS      = `HEAD_COUNT,
   parameter int FIFO_DEPTH = `TX_FIFO_DEPTH,
   parameter int HALF_CYC   = `TX_HALF_CYCLES
) (
   input  wire logic                                sys_clk_in,
   input  wire logic                                rst_n_in,
   input  wire galvo_pkg::coord_pair_t [HEADS-1:0]  coord_in,
   input  wire logic [HEADS-1:0]                    coord_valid_in,
   output logic [HEADS-1:0]                         coord_ready_out,
   output logic [HEADS-1:0]                         tx_busy_out,
   output logic [HEADS-1:0]                         tx_bit_clock_out,
   output logic [HEADS-1:0]                         tx_frame_sync_out,
   output logic [HEADS-1:0]                         tx_x_coord_line_out,
   output logic [HEADS-1:0]                         tx_y_coord_line_out,
   input  wire logic [HEADS-1:0]                    rx_bit_clock_in,
   input  wire logic [HEADS-1:0]                    rx_frame_sync_in,
   input  wire logic [HEADS-1:0]                    rx_status_line_in,
   input  wire logic [HEADS-1:0]                    rx_xor_echo_line_in,
   output galvo_pkg::rx_word_t [HEADS-1:0]          rx_word_out,
   output logic [HEADS-1:0]                         rx_valid_out,
   output logic [HEADS-1:0]                         rx_frame_error_out,
   output logic [HEADS-1:0]                         link_error_out
);

   localparam int DW = $clog2(HALF_CYC + 1);

   // Echo expected back from the head for one coordinate pair.
   function automatic logic [15:0] pair_echo(input galvo_pkg::coord_pair_t p);
      pair_echo = p.x ^ p.y;
   endfunction : pair_echo

   ////////////////////////////////////////////////////////////////////////////
   // One independent transmitter and receiver per head.
   genvar h;
   generate
      for (h = 0; h < HEADS; h++) begin : g_head

         logic                    fifo_in_ready;
         logic                    fifo_out_valid;
         galvo_pkg::coord_pair_t  fifo_out_data;
         logic                    pop;
         logic                    load;
         logic                    rise;
         logic                    staged_ff;
         logic [DW-1:0]           div_cnt_ff;
         logic                    bclk_ff;
         galvo_pkg::tx_state_t    state_ff;
         galvo_pkg::tx_state_t    nxt_state;
         logic [3:0]              tx_cnt_ff;
         logic [15:0]             sh_x_ff;
         logic [15:0]             sh_y_ff;
         logic                    fs_ff;
         logic [15:0]             pend_echo_ff;
         logic [15:0]             sent_echo_ff;

         logic                    rrst_a_ff;
         logic                    rrst_b_ff;
         logic                    rst_req_ff;
         logic                    ack_s1_ff;
         logic                    ack_s2_ff;
         logic [15:0]             rsh_st_ff;
         logic [15:0]             rsh_ec_ff;
         logic [3:0]              rx_cnt_ff;
         logic                    in_frame_ff;
         galvo_pkg::rx_word_t     rword_ff;
         logic                    rtog_ff;

         logic                    tog_s1_ff;
         logic                    tog_s2_ff;
         logic                    tog_s3_ff;
         galvo_pkg::rx_word_t     word_out_ff;
         logic                    valid_ff;
         logic                    ferr_ff;
         logic                    lerr_ff;

         /////////////////////////////////////////////////////////////////////
         // Coordinate FIFO; a full FIFO stalls the user through its ready.
         coord_fifo #(
            .WIDTH ($bits(galvo_pkg::coord_pair_t)),
            .DEPTH (FIFO_DEPTH)
         ) u_fifo (
            .sys_clk_in    (sys_clk_in),
            .rst_n_in      (rst_n_in),
            .in_valid_in   (coord_valid_in[h]),
            .in_ready_out  (fifo_in_ready),
            .in_data_in    (coord_in[h]),
            .out_valid_out (fifo_out_valid),
            .out_ready_in  (pop),
            .out_data_out  (fifo_out_data)
         );

         assign pop = fifo_out_valid && !staged_ff;

         always_ff @(posedge sys_clk_in) begin
            if (!rst_n_in) begin
               staged_ff <= 1'b0;
            end else if (pop) begin
               staged_ff <= 1'b1;
            end else if (load) begin
               staged_ff <= 1'b0;
            end
         end

         /////////////////////////////////////////////////////////////////////
         // Bit clock divider; every change on the lines happens with a rising edge.
         assign rise = (div_cnt_ff == DW'(HALF_CYC - 1)) && !bclk_ff;

         always_ff @(posedge sys_clk_in) begin
            if (!rst_n_in) begin
               div_cnt_ff <= '0;
               bclk_ff    <= 1'b0;
            end else if (div_cnt_ff == DW'(HALF_CYC - 1)) begin
               div_cnt_ff <= '0;
               bclk_ff    <= !bclk_ff;
            end else begin
               div_cnt_ff <= DW'(div_cnt_ff + 1'b1);
            end
         end

         /////////////////////////////////////////////////////////////////////
         // Transmit state machine.
         assign load = rise && (state_ff == galvo_pkg::TX_IDLE) && staged_ff;

         always_comb begin
            nxt_state = state_ff;
            case (state_ff)
               galvo_pkg::TX_IDLE: begin
                  if (load) begin
                     nxt_state = galvo_pkg::TX_SHIFT;
                  end
               end
               galvo_pkg::TX_SHIFT: begin
                  if (rise && (tx_cnt_ff == `BIT_COUNT_LAST)) begin
                     nxt_state = galvo_pkg::TX_IDLE;
                  end
               end
               default: begin
                  nxt_state = galvo_pkg::TX_IDLE;
               end
            endcase
         end

         always_ff @(posedge sys_clk_in) begin
            if (!rst_n_in) begin
               state_ff <= galvo_pkg::TX_IDLE;
            end else begin
               state_ff <= nxt_state;
            end
         end

         always_ff @(posedge sys_clk_in) begin
            if (!rst_n_in) begin
               tx_cnt_ff <= `BIT_COUNT_RESET;
               sh_x_ff   <= `WORD_RESET;
               sh_y_ff   <= `WORD_RESET;
               fs_ff     <= 1'b0;
            end else if (load) begin
               tx_cnt_ff <= `BIT_COUNT_RESET;
               sh_x_ff   <= fifo_out_data.x;
               sh_y_ff   <= fifo_out_data.y;
               fs_ff     <= 1'b1;
            end else if (rise && (state_ff == galvo_pkg::TX_SHIFT)) begin
               tx_cnt_ff <= 4'(tx_cnt_ff + 1'b1);
               sh_x_ff   <= {sh_x_ff[14:0], 1'b0};
               sh_y_ff   <= {sh_y_ff[14:0], 1'b0};
               if (tx_cnt_ff == `BIT_COUNT_LAST) begin
                  fs_ff <= 1'b0;
               end
            end
         end

         always_ff @(posedge sys_clk_in) begin
            if (!rst_n_in) begin
               pend_echo_ff <= `WORD_RESET;
               sent_echo_ff <= `WORD_RESET;
            end else if (load) begin
               pend_echo_ff <= pair_echo(fifo_out_data);
            end else if (rise && (state_ff == galvo_pkg::TX_SHIFT) && (tx_cnt_ff == `BIT_COUNT_LAST)) begin
               sent_echo_ff <= pend_echo_ff;
            end
         end

         assign coord_ready_out[h]     = fifo_in_ready;
         assign tx_busy_out[h]         = fs_ff;
         assign tx_bit_clock_out[h]    = bclk_ff;
         assign tx_frame_sync_out[h]   = fs_ff;
         assign tx_x_coord_line_out[h] = sh_x_ff[`COORD_MSB];
         assign tx_y_coord_line_out[h] = sh_y_ff[`COORD_MSB];

         /////////////////////////////////////////////////////////////////////
         // Receive reset request; a short reset is held here until the receive side reports it.
         always_ff @(posedge sys_clk_in) begin
            if (!rst_n_in) begin
               rst_req_ff <= 1'b1;
               ack_s1_ff  <= 1'b0;
               ack_s2_ff  <= 1'b0;
            end else begin
               ack_s1_ff <= rrst_b_ff;
               ack_s2_ff <= ack_s1_ff;
               if (ack_s2_ff) begin
                  rst_req_ff <= 1'b0;
               end
            end
         end

         /////////////////////////////////////////////////////////////////////
         // Receive side on the head's own clock, sampled on its falling edge.
         always_ff @(negedge rx_bit_clock_in[h]) begin
            rrst_a_ff <= rst_req_ff;
            rrst_b_ff <= rrst_a_ff;
         end

         always_ff @(negedge rx_bit_clock_in[h]) begin
            if (rrst_b_ff) begin
               rsh_st_ff   <= `WORD_RESET;
               rsh_ec_ff   <= `WORD_RESET;
               rx_cnt_ff   <= `BIT_COUNT_RESET;
               in_frame_ff <= 1'b0;
               rword_ff    <= '0;
               rtog_ff     <= 1'b0;
            end else if (rx_frame_sync_in[h]) begin
               rsh_st_ff   <= {rsh_st_ff[14:0], rx_status_line_in[h]};
               rsh_ec_ff   <= {rsh_ec_ff[14:0], rx_xor_echo_line_in[h]};
               in_frame_ff <= 1'b1;
               if (rx_cnt_ff == `BIT_COUNT_LAST) begin
                  rx_cnt_ff            <= `BIT_COUNT_RESET;
                  rword_ff.short_frame <= 1'b0;
                  rword_ff.status      <= {rsh_st_ff[14:0], rx_status_line_in[h]};
                  rword_ff.echo        <= {rsh_ec_ff[14:0], rx_xor_echo_line_in[h]};
                  rtog_ff              <= !rtog_ff;
               end else begin
                  rx_cnt_ff <= 4'(rx_cnt_ff + 1'b1);
               end
            end else begin
               rx_cnt_ff   <= `BIT_COUNT_RESET;
               in_frame_ff <= 1'b0;
               if (in_frame_ff && (rx_cnt_ff != `BIT_COUNT_RESET)) begin
                  rword_ff.short_frame <= 1'b1;
                  rword_ff.status      <= rsh_st_ff;
                  rword_ff.echo        <= rsh_ec_ff;
                  rtog_ff              <= !rtog_ff;
               end
            end
         end

         /////////////////////////////////////////////////////////////////////
         // Toggle handshake into the system clock; the word is stable meanwhile.
         always_ff @(posedge sys_clk_in) begin
            if (!rst_n_in) begin
               tog_s1_ff <= 1'b0;
               tog_s2_ff <= 1'b0;
               tog_s3_ff <= 1'b0;
            end else begin
               tog_s1_ff <= rtog_ff;
               tog_s2_ff <= tog_s1_ff;
               tog_s3_ff <= tog_s2_ff;
            end
         end

         always_ff @(posedge sys_clk_in) begin
            if (!rst_n_in) begin
               word_out_ff <= '0;
               valid_ff    <= 1'b0;
               ferr_ff     <= 1'b0;
               lerr_ff     <= 1'b0;
            end else begin
               valid_ff <= 1'b0;
               ferr_ff  <= 1'b0;
               lerr_ff  <= 1'b0;
               if (tog_s2_ff != tog_s3_ff) begin
                  word_out_ff <= rword_ff;
                  if (rword_ff.short_frame) begin
                     ferr_ff <= 1'b1;
                  end else begin
                     valid_ff <= 1'b1;
                     lerr_ff  <= (rword_ff.echo != sent_echo_ff);
                  end
               end
            end
         end

         assign rx_word_out[h]        = word_out_ff;
         assign rx_valid_out[h]       = valid_ff;
         assign rx_frame_error_out[h] = ferr_ff;
         assign link_error_out[h]     = lerr_ff;

      end
   endgenerate

endmodule : galvo_serial_link
